/* verilog/fwe_map.svh */
// Register offsets, field positions, reset values and widths of the flash ECC wrapper.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef FWE_MAP_SVH
`define FWE_MAP_SVH

`define FWE_PAW 12
`define FWE_OFF_ECC_CTRL 12'h000
`define FWE_OFF_ERR_STAT 12'h004
`define FWE_OFF_CORR_CNT 12'h008
`define FWE_OFF_CORR_THR 12'h00c
`define FWE_OFF_ERR_ADDR 12'h010
`define FWE_OFF_CMD 12'h014
`define FWE_OFF_CMD_ADDR 12'h018
`define FWE_OFF_STATUS 12'h01c
`define FWE_OFF_CMD_GUARD 12'h020
`define FWE_OFF_STAT_GUARD 12'h024
`define FWE_OFF_GUARD_LOCK 12'h028
`define FWE_OFF_DATA_LO 12'h02c
`define FWE_OFF_DATA_HI 12'h030
`define FWE_OFF_OP_CFG 12'h034
`define FWE_OFF_ECC_DATA 12'h038

`define FWE_CTRL_CORR_EN 0
`define FWE_CTRL_TEST_EN 1
`define FWE_CTRL_RESET 2'h1
`define FWE_ERR_UE 0
`define FWE_ERR_THR 1
`define FWE_OPCFG_ECC_OVR 0

`define FWE_ST_RUN 0
`define FWE_ST_DONE 1
`define FWE_ST_PASS 2
`define FWE_ST_FAIL_LSB 3
`define FWE_FAIL_INV_DATA 0
`define FWE_FAIL_PROG_VFY 1
`define FWE_FAIL_ERASE_VFY 2
`define FWE_FAIL_PROTECT 3
`define FWE_FAIL_BAD_CMD 4
`define FWE_NFAIL 5

`define FWE_DATA_RESET 32'hffffffff

`endif

/* verilog/fwe_pkg.sv */
// Types shared by the flash ECC wrapper.
// Assumes nothing beyond a SystemVerilog compiler.
package fwe_pkg;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_CHKRD = 8'h02,
    ST_CHKWT = 8'h04,
    ST_PROG  = 8'h08,
    ST_ERASE = 8'h10,
    ST_VRD   = 8'h20,
    ST_VWT   = 8'h40,
    ST_FIN   = 8'h80
  } fwe_state_t;

  typedef enum logic [1:0] {
    CMD_PROGRAM = 2'h1,
    CMD_ERASE   = 2'h2,
    CMD_CLEAR   = 2'h3
  } fwe_cmd_t;

  typedef struct packed {
    logic [63:0] data;
    logic ce;
    logic ue;
  } fwe_dec_t;

endpackage

/* verilog/fwe_flash_wrapper.sv */
// Flash wrapper: read ECC checking, error logging, command sequencer with protection.
// Assumes an APB master, a CPU read port and a flash bank on the same CLK_SYS.
//
// Behaviour
// (R1) Each 64-bit word plus its address carries an 8-bit SECDED code.
// (R2) Every bank read, CPU or internal, is checked at the bank output.
// (R3) Single data errors are corrected only while correction is enabled.
// (R4) A single error in the address part counts as uncorrectable.
// (R5) Uncorrectable errors pulse NMI and raise the error status pin.
// (R6) Corrected data errors are counted; above threshold an interrupt flag rises.
// (R7) The address of the latest faulty read is logged, replacing older ones.
// (R8) Program and erase are verified by read back; failures set status flags.
// (R9) Lockable static sector guard blocks program and erase to its sectors.
// (R10) Per-command guard resets to all protected at reset and after each command.
// (R11) Program data buffer returns to all ones after every command.
// (R12) Status updates for all commands; status clear does not mark itself.
// (R13) Status has running, finished and success flags.
// (R14) Status has five distinct failure bits.
// (R15) Setting the finished flag pulses a done interrupt.
// (R16) Program that would turn a 0 into 1 fails with invalid data, no write.
// (R17) Code generation and checking use separate logic.
// (R18) Override bit writes check bits from a register instead of generated ones.
// (R19) Self-test makes the redundant checkers disagree on a read.
// (R20) Scrubbing masters issue dummy reads; checking follows from ordinary reads.
// (R21) A blocked command ends finished, not successful, flash untouched.
`timescale 1ns/1ps
`include "fwe_map.svh"

module fwe_flash_wrapper #(
  parameter int AW = 20,
  parameter int NSECT = 16,
  parameter int CW = 16
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`FWE_PAW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RD_REQ,
  input wire logic [AW-1:0] RD_ADDR,
  output logic RD_READY,
  output logic RD_VALID,
  output logic [63:0] RD_DATA,
  output logic RD_ERR,
  output logic BANK_RD,
  output logic [AW-1:0] BANK_ADDR,
  input wire logic [63:0] BANK_RDATA,
  input wire logic [7:0] BANK_RECC,
  output logic BANK_PROG,
  output logic BANK_ERASE,
  output logic [63:0] BANK_WDATA,
  output logic [7:0] BANK_WECC,
  input wire logic BANK_DONE,
  output logic NMI,
  output logic ERROR_STATUS,
  output logic CORR_IRQ,
  output logic DONE_IRQ
);

  localparam int SB = $clog2(NSECT);

  // Column of the parity matrix for data bit k (k < 64) or address bit k - 64
  function automatic logic [6:0] fwe_col(input int k);
    int n;
    logic [6:0] r;
    n = 0;
    r = 7'h00;
    for (int v = 3; v < 128; v++) begin
      if ((v & (v - 1)) != 0) begin
        if (n == k) r = 7'(v);
        n++;
      end
    end
    return r;
  endfunction

  // Code generator used only on the program path
  function automatic logic [7:0] fwe_gen(input logic [63:0] d, input logic [AW-1:0] a);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < 64; i++) if (d[i]) c = c ^ fwe_col(i);
    for (int j = 0; j < AW; j++) if (a[j]) c = c ^ fwe_col(64 + j);
    return {^{d, a, c}, c};
  endfunction

  // Checker used only on the read path
  function automatic fwe_pkg::fwe_dec_t fwe_check(input logic [63:0] d, input logic [AW-1:0] a,
                                                  input logic [7:0] e, input logic corr_en);
    fwe_pkg::fwe_dec_t r;
    logic [6:0] c;
    logic [7:0] syn;
    logic [63:0] flip;
    logic hit;
    logic cbit;
    c = 7'h00;
    flip = 64'h0;
    hit = 1'b0;
    for (int i = 0; i < 64; i++) if (d[i]) c = c ^ fwe_col(i);
    for (int j = 0; j < AW; j++) if (a[j]) c = c ^ fwe_col(64 + j); // see (R1)
    syn = {^{d, a, e}, c ^ e[6:0]};
    for (int i = 0; i < 64; i++) begin
      if (syn[6:0] == fwe_col(i)) begin
        flip[i] = 1'b1;
        hit = 1'b1;
      end
    end
    cbit = (syn[6:0] & (syn[6:0] - 7'h01)) == 7'h00;
    r.ce = syn[7] & hit;
    r.ue = (syn != 8'h00) & ~(syn[7] & (hit | cbit)); // see (R4)
    r.data = (r.ce & corr_en) ? d ^ flip : d; // see (R3)
    return r;
  endfunction

  fwe_pkg::fwe_state_t state;
  fwe_pkg::fwe_state_t next_state;
  logic corr_en;
  logic test_en;
  logic ecc_ovr;
  logic [7:0] ecc_data;
  logic ue_flag;
  logic thr_flag;
  logic [CW-1:0] corr_cnt;
  logic [CW-1:0] corr_thr;
  logic [AW-1:0] err_addr;
  logic [AW-1:0] cmd_addr;
  logic [1:0] cmd_code;
  logic running;
  logic done;
  logic pass;
  logic [`FWE_NFAIL-1:0] fail;
  logic [`FWE_NFAIL-1:0] next_fail;
  logic [NSECT-1:0] cmd_guard;
  logic [NSECT-1:0] stat_guard;
  logic guard_lock;
  logic [31:0] data_lo;
  logic [31:0] data_hi;
  logic pend_cpu;
  logic pend_fsm;
  logic [AW-1:0] pend_addr;
  logic fsm_rd;
  logic cpu_go;
  logic wr;
  logic cmd_wr;
  logic [SB-1:0] sect;
  logic [63:0] buf_data;
  fwe_pkg::fwe_dec_t dec [2];
  logic chk_ue;
  logic chk_ce;
  logic pend_any;

  assign wr = PSEL & PENABLE & PWRITE;
  assign cmd_wr = wr & (PADDR == `FWE_OFF_CMD) & state[0];
  assign sect = cmd_addr[AW-1 -: SB];
  assign buf_data = {data_hi, data_lo};
  assign pend_any = pend_cpu | pend_fsm;

  // Bank read port, internal reads take precedence
  assign fsm_rd = (state == fwe_pkg::ST_CHKRD) | (state == fwe_pkg::ST_VRD);
  assign RD_READY = ~fsm_rd;
  assign cpu_go = RD_REQ & ~fsm_rd; // see (R20)
  assign BANK_RD = fsm_rd | cpu_go;
  // Program and erase pulses also need the command address on the bank port
  assign BANK_ADDR = (fsm_rd | BANK_PROG | BANK_ERASE) ? cmd_addr : RD_ADDR;

  // Two redundant checkers; self-test flips one bit into the second
  generate
    for (genvar g = 0; g < 2; g++) begin : g_chk
      logic [63:0] din;
      assign din = BANK_RDATA ^ {63'h0, test_en & (g == 1)}; // see (R19)
      assign dec[g] = fwe_check(din, pend_addr, BANK_RECC, corr_en); // see (R2) (R17)
    end
  endgenerate

  assign chk_ue = pend_any & (dec[0].ue | (dec[0] != dec[1])); // see (R19)
  assign chk_ce = pend_any & dec[0].ce & (dec[0] == dec[1]);

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pend_cpu <= 1'b0;
      pend_fsm <= 1'b0;
      pend_addr <= '0;
    end else begin
      pend_cpu <= cpu_go;
      pend_fsm <= fsm_rd;
      pend_addr <= BANK_ADDR;
    end
  end

  // CPU read answer
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      RD_VALID <= 1'b0;
      RD_DATA <= 64'h0;
      RD_ERR <= 1'b0;
    end else begin
      RD_VALID <= pend_cpu;
      RD_ERR <= pend_cpu & chk_ue;
      if (pend_cpu) begin
        RD_DATA <= dec[0].data;
      end
    end
  end

  // Error flags, counter and address log
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ue_flag <= 1'b0;
      thr_flag <= 1'b0;
      NMI <= 1'b0;
      corr_cnt <= '0;
      err_addr <= '0;
    end else begin
      NMI <= chk_ue; // see (R5)
      if (chk_ue) begin
        ue_flag <= 1'b1;
      end else if (wr && PADDR == `FWE_OFF_ERR_STAT && PWDATA[`FWE_ERR_UE]) begin
        ue_flag <= 1'b0;
      end
      if (corr_cnt > corr_thr) begin
        thr_flag <= 1'b1; // see (R6)
      end else if (wr && PADDR == `FWE_OFF_ERR_STAT && PWDATA[`FWE_ERR_THR]) begin
        thr_flag <= 1'b0;
      end
      if (chk_ce && corr_cnt != '1) begin
        corr_cnt <= corr_cnt + 1'b1; // see (R6)
      end else if (wr && PADDR == `FWE_OFF_CORR_CNT) begin
        corr_cnt <= '0;
      end
      if (chk_ue | chk_ce) begin
        err_addr <= pend_addr; // see (R7)
      end
    end
  end

  assign ERROR_STATUS = ue_flag; // see (R5)
  assign CORR_IRQ = thr_flag;

  // Software configuration
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      corr_en <= 1'(`FWE_CTRL_RESET);
      test_en <= 1'b0;
      corr_thr <= '0;
      cmd_addr <= '0;
      ecc_ovr <= 1'b0;
      ecc_data <= 8'h00;
      stat_guard <= '0;
      guard_lock <= 1'b0;
      cmd_code <= 2'h0;
    end else begin
      if (wr) begin
        case (PADDR)
          `FWE_OFF_ECC_CTRL: begin
            corr_en <= PWDATA[`FWE_CTRL_CORR_EN];
            test_en <= PWDATA[`FWE_CTRL_TEST_EN];
          end
          `FWE_OFF_CORR_THR: corr_thr <= PWDATA[CW-1:0];
          `FWE_OFF_CMD_ADDR: if (state[0]) cmd_addr <= PWDATA[AW-1:0];
          `FWE_OFF_OP_CFG: ecc_ovr <= PWDATA[`FWE_OPCFG_ECC_OVR];
          `FWE_OFF_ECC_DATA: ecc_data <= PWDATA[7:0];
          `FWE_OFF_STAT_GUARD: if (!guard_lock) stat_guard <= PWDATA[NSECT-1:0]; // see (R9)
          `FWE_OFF_GUARD_LOCK: if (PWDATA[0]) guard_lock <= 1'b1; // see (R9)
          default: ;
        endcase
      end
      if (cmd_wr) begin
        cmd_code <= PWDATA[1:0];
      end
    end
  end

  // Command sequencer
  always_comb begin
    next_state = state;
    next_fail = fail;
    case (state)
      fwe_pkg::ST_IDLE: begin
        if (cmd_wr) begin
          next_fail = '0;
          case (PWDATA[1:0])
            fwe_pkg::CMD_PROGRAM, fwe_pkg::CMD_ERASE: begin
              if (stat_guard[sect] | cmd_guard[sect]) begin
                next_fail[`FWE_FAIL_PROTECT] = 1'b1; // see (R9) (R10) (R21)
                next_state = fwe_pkg::ST_FIN;
              end else if (PWDATA[1:0] == fwe_pkg::CMD_PROGRAM) begin
                next_state = fwe_pkg::ST_CHKRD;
              end else begin
                next_state = fwe_pkg::ST_ERASE;
              end
            end
            fwe_pkg::CMD_CLEAR: next_state = fwe_pkg::ST_IDLE;
            default: begin
              next_fail[`FWE_FAIL_BAD_CMD] = 1'b1; // see (R14)
              next_state = fwe_pkg::ST_FIN;
            end
          endcase
        end
      end
      fwe_pkg::ST_CHKRD: next_state = fwe_pkg::ST_CHKWT;
      fwe_pkg::ST_CHKWT: begin
        if (chk_ue || (~dec[0].data & buf_data) != 64'h0) begin
          next_fail[`FWE_FAIL_INV_DATA] = 1'b1; // see (R16)
          next_state = fwe_pkg::ST_FIN;
        end else begin
          next_state = fwe_pkg::ST_PROG;
        end
      end
      fwe_pkg::ST_PROG, fwe_pkg::ST_ERASE: if (BANK_DONE) next_state = fwe_pkg::ST_VRD;
      fwe_pkg::ST_VRD: next_state = fwe_pkg::ST_VWT;
      fwe_pkg::ST_VWT: begin
        if (cmd_code == fwe_pkg::CMD_PROGRAM) begin
          if (chk_ue || dec[0].data != buf_data) next_fail[`FWE_FAIL_PROG_VFY] = 1'b1; // see (R8)
        end else begin
          if (chk_ue || dec[0].data != 64'hffffffffffffffff) next_fail[`FWE_FAIL_ERASE_VFY] = 1'b1; // see (R8)
        end
        next_state = fwe_pkg::ST_FIN;
      end
      fwe_pkg::ST_FIN: next_state = fwe_pkg::ST_IDLE;
      default: next_state = fwe_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state <= fwe_pkg::ST_IDLE;
      fail <= '0;
    end else begin
      state <= next_state;
      fail <= next_fail;
    end
  end

  // Status flags and done event
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      running <= 1'b0;
      done <= 1'b0;
      pass <= 1'b0;
      DONE_IRQ <= 1'b0;
    end else begin
      DONE_IRQ <= state == fwe_pkg::ST_FIN; // see (R15)
      if (state == fwe_pkg::ST_FIN) begin
        running <= 1'b0;
        done <= 1'b1; // see (R13)
        pass <= fail == '0;
      end else if (cmd_wr && PWDATA[1:0] == fwe_pkg::CMD_CLEAR) begin
        done <= 1'b0; // see (R12)
        pass <= 1'b0;
      end else if (cmd_wr) begin
        running <= 1'b1; // see (R12) (R13)
        done <= 1'b0;
        pass <= 1'b0;
      end
    end
  end

  // Guard and data buffer, restored after every command
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      cmd_guard <= '1;
      data_lo <= `FWE_DATA_RESET;
      data_hi <= `FWE_DATA_RESET;
    end else if (state == fwe_pkg::ST_FIN || (cmd_wr && PWDATA[1:0] == fwe_pkg::CMD_CLEAR)) begin
      cmd_guard <= '1; // see (R10)
      data_lo <= `FWE_DATA_RESET; // see (R11)
      data_hi <= `FWE_DATA_RESET;
    end else if (wr && state[0]) begin
      if (PADDR == `FWE_OFF_CMD_GUARD) cmd_guard <= PWDATA[NSECT-1:0]; // see (R10)
      if (PADDR == `FWE_OFF_DATA_LO) data_lo <= PWDATA;
      if (PADDR == `FWE_OFF_DATA_HI) data_hi <= PWDATA;
    end
  end

  // Program and erase strobes to the bank
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      BANK_PROG <= 1'b0;
      BANK_ERASE <= 1'b0;
      BANK_WDATA <= 64'h0;
      BANK_WECC <= 8'h00;
    end else begin
      BANK_PROG <= (state == fwe_pkg::ST_CHKWT) & (next_state == fwe_pkg::ST_PROG); // see (R16)
      BANK_ERASE <= state[0] & (next_state == fwe_pkg::ST_ERASE);
      if (state == fwe_pkg::ST_CHKWT) begin
        BANK_WDATA <= buf_data;
        BANK_WECC <= ecc_ovr ? ecc_data : fwe_gen(buf_data, cmd_addr); // see (R18) (R17) (R1)
      end
    end
  end

  // APB slave, zero wait states
  assign PREADY = 1'b1;
  always_comb begin
    PRDATA = 32'h0;
    PSLVERR = 1'b0;
    case (PADDR)
      `FWE_OFF_ECC_CTRL: PRDATA = {30'h0, test_en, corr_en};
      `FWE_OFF_ERR_STAT: PRDATA = {30'h0, thr_flag, ue_flag};
      `FWE_OFF_CORR_CNT: PRDATA = 32'(corr_cnt);
      `FWE_OFF_CORR_THR: PRDATA = 32'(corr_thr);
      `FWE_OFF_ERR_ADDR: PRDATA = 32'(err_addr);
      `FWE_OFF_CMD: PRDATA = 32'h0;
      `FWE_OFF_CMD_ADDR: PRDATA = 32'(cmd_addr);
      `FWE_OFF_STATUS: PRDATA = {24'h0, fail, pass, done, running}; // see (R13) (R14)
      `FWE_OFF_CMD_GUARD: PRDATA = 32'(cmd_guard);
      `FWE_OFF_STAT_GUARD: PRDATA = 32'(stat_guard);
      `FWE_OFF_GUARD_LOCK: PRDATA = {31'h0, guard_lock};
      `FWE_OFF_DATA_LO: PRDATA = data_lo;
      `FWE_OFF_DATA_HI: PRDATA = data_hi;
      `FWE_OFF_OP_CFG: PRDATA = {31'h0, ecc_ovr};
      `FWE_OFF_ECC_DATA: PRDATA = {24'h0, ecc_data};
      default: PSLVERR = PSEL & PENABLE;
    endcase
  end

endmodule

/* tb/fwe_bank_model.sv */
// Flash bank model: word store, one-cycle read latency, program and erase with done pulse.
// Assumes the wrapper's bank port on the same clock; the bench may inject bit flips.
`timescale 1ns/1ps
module fwe_bank_model #(
  parameter int AW = 20
) (
  input wire logic clk,
  input wire logic rd,
  input wire logic [AW-1:0] addr,
  output logic [63:0] rdata,
  output logic [7:0] recc,
  input wire logic prog,
  input wire logic erase,
  input wire logic [63:0] wdata,
  input wire logic [7:0] wecc,
  output logic done
);
  logic [63:0] mem [logic [AW-1:0]];
  logic [7:0] code [logic [AW-1:0]];
  logic [63:0] flip_d = '0;
  logic stuck = 1'b0;
  logic [AW-1:0] wa;
  logic pe;
  // Column k is the k-th non-power-of-two, data then address
  function automatic logic [7:0] ecc_of(logic [63:0] d, logic [AW-1:0] a);
    logic [6:0] h;
    logic [6:0] col;
    logic [63+AW:0] v;
    h = '0;
    col = 7'h2;
    v = {a, d};
    for (int i = 0; i < 64 + AW; i++) begin
      col++;
      while ((col & (col - 7'h1)) == 7'h0) col++;
      if (v[i]) h ^= col;
    end
    return {^{v, h}, h};
  endfunction
  function automatic logic [63:0] word(logic [AW-1:0] a);
    return mem.exists(a) ? mem[a] : '1;
  endfunction
  initial begin
    rdata = '0;
    recc = '0;
    done = 1'b0;
  end
  // Released bus shows inverted data
  always @(posedge clk) begin
    if (rd) begin
      rdata <= word(addr) ^ flip_d;
      recc <= code.exists(addr) ? code[addr] : ecc_of('1, addr);
    end else begin
      rdata <= ~rdata;
      recc <= ~recc;
    end
  end
  always @(posedge clk) begin
    if (prog || erase) begin
      wa = addr;
      pe = erase;
      repeat (3) @(posedge clk);
      if (!stuck && !pe) begin
        mem[wa] = word(wa) & wdata;
        code[wa] = wecc;
      end
      if (!stuck && pe) begin
        mem.delete(wa);
        code.delete(wa);
      end
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
    end
  end
endmodule

/* tb/fwe_flash_wrapper_checker.sv */
// Checker for the flash ECC wrapper port timing.
// Assumes binding into fwe_flash_wrapper on CLK_SYS.
`timescale 1ns/1ps
module fwe_flash_wrapper_checker (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic RD_REQ,
  input wire logic RD_READY,
  input wire logic RD_VALID,
  input wire logic RD_ERR,
  input wire logic BANK_RD,
  input wire logic BANK_PROG,
  input wire logic BANK_ERASE,
  input wire logic NMI,
  input wire logic ERROR_STATUS,
  input wire logic CORR_IRQ,
  input wire logic DONE_IRQ
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);
  a_rd_answer: assert property (RD_REQ && RD_READY |-> ##2 RD_VALID)
    else $error("cpu read not answered");
  a_valid_cause: assert property (RD_VALID |-> $past(RD_REQ && RD_READY, 2))
    else $error("read answer without request");
  a_rd_block: assert property (!RD_READY |-> BANK_RD)
    else $error("cpu port blocked without bank read");
  a_err_nmi: assert property (RD_VALID && RD_ERR |-> NMI)
    else $error("uncorrectable read without nmi");
  a_nmi_status: assert property (NMI |-> ##[0:1] ERROR_STATUS)
    else $error("nmi without error status");
  a_err_valid: assert property (RD_ERR |-> RD_VALID)
    else $error("error flag outside answer");
  a_done_pulse: assert property (DONE_IRQ |=> !DONE_IRQ)
    else $error("done event longer than one cycle");
  a_bank_pulse: assert property (BANK_PROG || BANK_ERASE |=> !(BANK_PROG || BANK_ERASE))
    else $error("bank operation pulse too long");
  a_prog_check: assert property (BANK_PROG |-> $past(BANK_RD, 2))
    else $error("program without data check read");
  c_uncorr: cover property (RD_VALID && RD_ERR);
  c_done: cover property (DONE_IRQ);
  c_thresh: cover property ($rose(CORR_IRQ));
endmodule
bind fwe_flash_wrapper fwe_flash_wrapper_checker chk_i (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
  .RD_REQ(RD_REQ), .RD_READY(RD_READY), .RD_VALID(RD_VALID), .RD_ERR(RD_ERR), .BANK_RD(BANK_RD),
  .BANK_PROG(BANK_PROG), .BANK_ERASE(BANK_ERASE), .NMI(NMI), .ERROR_STATUS(ERROR_STATUS),
  .CORR_IRQ(CORR_IRQ), .DONE_IRQ(DONE_IRQ));

/* tb/fwe_flash_wrapper_bench.sv */
// Bench for the flash ECC wrapper: APB and CPU read tasks against a bank model.
// Assumes wrapper defaults AW=20, NSECT=16 and the register map header.
`timescale 1ns/1ps
`include "fwe_map.svh"
module fwe_flash_wrapper_bench;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, rd_req = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [19:0] rd_addr = 0, bank_addr;
  logic [63:0] rd_data, bank_rdata, bank_wdata;
  logic [7:0] bank_recc, bank_wecc;
  logic pready, pslverr, rd_ready, rd_valid, rd_err, bank_rd, bank_prog, bank_erase, bank_done;
  logic nmi, err_st, corr_irq, done_irq, e;
  int miscompares = 0, tests_run = 0, cyc = 0, dcnt = 0, ncnt = 0, pcnt = 0;
  fwe_flash_wrapper uut (.CLK_SYS(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RD_REQ(rd_req), .RD_ADDR(rd_addr), .RD_READY(rd_ready), .RD_VALID(rd_valid), .RD_DATA(rd_data),
    .RD_ERR(rd_err), .BANK_RD(bank_rd), .BANK_ADDR(bank_addr), .BANK_RDATA(bank_rdata),
    .BANK_RECC(bank_recc), .BANK_PROG(bank_prog), .BANK_ERASE(bank_erase), .BANK_WDATA(bank_wdata),
    .BANK_WECC(bank_wecc), .BANK_DONE(bank_done), .NMI(nmi), .ERROR_STATUS(err_st),
    .CORR_IRQ(corr_irq), .DONE_IRQ(done_irq));
  fwe_bank_model bank (.clk(clk), .rd(bank_rd), .addr(bank_addr), .rdata(bank_rdata), .recc(bank_recc),
    .prog(bank_prog), .erase(bank_erase), .wdata(bank_wdata), .wecc(bank_wecc), .done(bank_done));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    dcnt += int'(done_irq === 1'b1);
    ncnt += int'(nmi === 1'b1);
    pcnt += int'(bank_prog === 1'b1);
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] x, input string n);
    tests_run++;
    if (s !== x) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic s);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    s = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x, n);
  endtask
  // Error kind: 0 clean, 1 uncorrectable, 2 not judged
  task automatic cpu(input logic [19:0] a, input logic [63:0] d, input int x);
    rd_req <= 1'b1;
    rd_addr <= a;
    do @(posedge clk); while (rd_ready !== 1'b1);
    rd_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk(rd_valid, 1'b1, "rd_valid");
    if (x != 2) chk(rd_err, x[0], "rd_err");
    if (x == 0) chk(rd_data, d, "rd_data");
    @(posedge clk);
  endtask
  task automatic cmd(input logic [1:0] c, input logic [19:0] a, input logic [7:0] x);
    wr(`FWE_OFF_CMD_ADDR, {12'h0, a});
    wr(`FWE_OFF_CMD, {30'h0, c});
    q = 32'h0;
    while (q[`FWE_ST_DONE] !== 1'b1) apb(1'b0, `FWE_OFF_STATUS, 32'h0, q, e);
    if (x != 8'hff) chk(q[7:0], x, "status");
    @(posedge clk);
  endtask
  initial begin
    logic [63:0] w;
    w = 64'h0123456789abcdef;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(`FWE_OFF_ECC_CTRL, 32'h1, "ecc_ctrl");
    rdc(`FWE_OFF_CMD_GUARD, 32'hffff, "cmd_guard");
    rdc(`FWE_OFF_DATA_HI, `FWE_DATA_RESET, "data_hi");
    rdc(`FWE_OFF_STATUS, 32'h0, "status");
    apb(1'b0, 12'h03c, 32'h0, q, e);
    chk(e, 1'b1, "pslverr");
    for (int i = 16; i < 18; i++) begin
      bank.mem[i] = w;
      bank.code[i] = bank.ecc_of(w, i);
    end
    bank.mem[20'h12] = w;
    bank.code[20'h12] = bank.ecc_of(w, 20'h13);
    cpu(20'h10, w, 0);
    wr(`FWE_OFF_CORR_THR, 32'h1);
    bank.flip_d = 64'h20;
    cpu(20'h10, w, 0);
    chk(corr_irq, 1'b0, "corr_irq");
    cpu(20'h11, w, 0);
    chk(corr_irq, 1'b1, "corr_irq");
    rdc(`FWE_OFF_CORR_CNT, 32'h2, "corr_cnt");
    rdc(`FWE_OFF_ERR_ADDR, 32'h11, "err_addr");
    wr(`FWE_OFF_ECC_CTRL, 32'h0);
    cpu(20'h10, w ^ 64'h20, 0);
    wr(`FWE_OFF_ECC_CTRL, 32'h1);
    bank.flip_d = 64'h3;
    cpu(20'h10, w, 1);
    chk(ncnt, 1, "nmi");
    chk(err_st, 1'b1, "error_status");
    rdc(`FWE_OFF_ERR_ADDR, 32'h10, "err_addr");
    bank.flip_d = 64'h0;
    cpu(20'h12, w, 1);
    wr(`FWE_OFF_ECC_CTRL, 32'h3);
    cpu(20'h11, w, 2);
    chk(ncnt, 3, "nmi");
    wr(`FWE_OFF_ECC_CTRL, 32'h1);
    wr(`FWE_OFF_DATA_LO, 32'h0);
    cmd(2'h1, 20'h10020, 8'h42);
    chk(pcnt, 0, "bank_prog");
    chk(dcnt, 1, "done_irq");
    rdc(`FWE_OFF_DATA_LO, `FWE_DATA_RESET, "data_lo");
    wr(`FWE_OFF_CMD_GUARD, 32'hfffd);
    wr(`FWE_OFF_DATA_LO, 32'h0000ffff);
    cmd(2'h1, 20'h10020, 8'h06);
    chk(bank.mem[20'h10020], 64'hffffffff0000ffff, "flash");
    rdc(`FWE_OFF_CMD_GUARD, 32'hffff, "cmd_guard");
    cpu(20'h10020, 64'hffffffff0000ffff, 0);
    wr(`FWE_OFF_CMD_GUARD, 32'hfffd);
    cmd(2'h1, 20'h10020, 8'h0a);
    chk(pcnt, 1, "bank_prog");
    wr(`FWE_OFF_CMD_GUARD, 32'hfffd);
    wr(`FWE_OFF_DATA_LO, 32'h0);
    bank.stuck = 1'b1;
    cmd(2'h1, 20'h10021, 8'h12);
    wr(`FWE_OFF_CMD_GUARD, 32'hfffd);
    cmd(2'h2, 20'h10020, 8'h22);
    bank.stuck = 1'b0;
    wr(`FWE_OFF_CMD_GUARD, 32'hfffd);
    cmd(2'h2, 20'h10020, 8'h06);
    chk(bank.mem.exists(20'h10020), 0, "erased");
    cmd(2'h0, 20'h10020, 8'h82);
    wr(`FWE_OFF_CMD, 32'h3);
    repeat (4) @(posedge clk);
    rdc(`FWE_OFF_STATUS, 32'h0, "status");
    chk(dcnt, 7, "done_irq");
    wr(`FWE_OFF_STAT_GUARD, 32'h4);
    wr(`FWE_OFF_GUARD_LOCK, 32'h1);
    wr(`FWE_OFF_STAT_GUARD, 32'h0);
    rdc(`FWE_OFF_STAT_GUARD, 32'h4, "stat_guard");
    wr(`FWE_OFF_CMD_GUARD, 32'hfffb);
    wr(`FWE_OFF_DATA_LO, 32'h0);
    cmd(2'h1, 20'h20000, 8'h42);
    wr(`FWE_OFF_OP_CFG, 32'h1);
    wr(`FWE_OFF_ECC_DATA, 32'h5a);
    wr(`FWE_OFF_CMD_GUARD, 32'hfffd);
    wr(`FWE_OFF_DATA_LO, 32'h0);
    cmd(2'h1, 20'h10030, 8'hff);
    chk(bank.code[20'h10030], 8'h5a, "bank_ecc");
    summarize();
  end
endmodule
